/* tb/beo_monitor.sv */
// Port checks for the beam evaluation options block.
// Assumes one clock domain and an active low async reset.
`timescale 1ns/1ns
`default_nettype none

module beo_monitor (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_B_IN,
  // Bus
  input wire logic HSEL_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic HREADY_IN,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  // Scanner and results
  input wire logic SCAN_DONE_IN,
  input wire logic HIGH_SPEED_OUT,
  input wire logic PARALLEL_OUT,
  input wire logic CROSS_SWITCH_OUT,
  input wire logic CROSS_MEASURE_OUT,
  input wire logic [beo_pkg::MAX_BEAMS-1:0] BEAM_STATE_OUT,
  input wire logic [5:0] BEAM_COUNT_OUT,
  input wire logic HOLD_ACTIVE_OUT,
  input wire logic TEACH_START_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // ==========================================================================
  // Bus timing
  sequence s_take;
    HSEL_IN && HREADY_IN && HTRANS_IN[1] && HREADYOUT_OUT;
  endsequence
  sequence s_one_wait;
    !HREADYOUT_OUT ##1 HREADYOUT_OUT;
  endsequence
  property p_rd_wait;
    s_take ##0 !HWRITE_IN |=> s_one_wait;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_nowait;
    s_take ##0 HWRITE_IN |=> HREADYOUT_OUT;
  endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_okay;
    HRESP_OUT == 1'h0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  // ==========================================================================
  // Scan method
  property p_fast;
    HIGH_SPEED_OUT |-> PARALLEL_OUT;
  endproperty
  a_fast: assert property (p_fast) else $error("high speed without parallel");
  property p_cross_slow;
    (CROSS_SWITCH_OUT || CROSS_MEASURE_OUT) |-> !HIGH_SPEED_OUT;
  endproperty
  a_cross_slow: assert property (p_cross_slow) else $error("cross with high speed");
  property p_one_cross;
    !(CROSS_SWITCH_OUT && CROSS_MEASURE_OUT);
  endproperty
  a_one_cross: assert property (p_one_cross) else $error("two cross functions");
  property p_count;
    $rose(CROSS_MEASURE_OUT) |-> ##[0:1] (BEAM_COUNT_OUT == beo_pkg::COUNT_MEASURE);
  endproperty
  a_count: assert property (p_count) else $error("beam count not renumbered");
  // ==========================================================================
  // Hold modes and inputs
  property p_held_keep;
    HOLD_ACTIVE_OUT && $past(HOLD_ACTIVE_OUT) |-> ($past(BEAM_STATE_OUT) & ~BEAM_STATE_OUT) == '0;
  endproperty
  a_held_keep: assert property (p_held_keep) else $error("latched beam dropped");
  property p_hold_scan;
    $changed(HOLD_ACTIVE_OUT) |-> $past(SCAN_DONE_IN, 2);
  endproperty
  a_hold_scan: assert property (p_hold_scan) else $error("hold changed off scan");
  property p_teach_pulse;
    TEACH_START_OUT |=> !TEACH_START_OUT;
  endproperty
  a_teach_pulse: assert property (p_teach_pulse) else $error("teach pulse too long");
endmodule : beo_monitor

bind beo_top beo_monitor u_mon (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN), .HSEL_IN(HSEL_IN), .HTRANS_IN(HTRANS_IN),
  .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
  .SCAN_DONE_IN(SCAN_DONE_IN), .HIGH_SPEED_OUT(HIGH_SPEED_OUT), .PARALLEL_OUT(PARALLEL_OUT),
  .CROSS_SWITCH_OUT(CROSS_SWITCH_OUT), .CROSS_MEASURE_OUT(CROSS_MEASURE_OUT),
  .BEAM_STATE_OUT(BEAM_STATE_OUT), .BEAM_COUNT_OUT(BEAM_COUNT_OUT),
  .HOLD_ACTIVE_OUT(HOLD_ACTIVE_OUT), .TEACH_START_OUT(TEACH_START_OUT)
);

`default_nettype wire

/* tb/beo_scan_model.sv */
// Scanner model: one done pulse per finished scan with its beam data.
// Assumes the caller enters the task just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none

module beo_scan_model (
  // Clock
  input wire logic clk_in,
  // Scanner outputs
  output logic [beo_pkg::NUM_BEAMS-1:0] beam_out,
  output logic [beo_pkg::NUM_CROSS-1:0] cross_out,
  output logic done_out
);
  initial begin
    beam_out = '0;
    cross_out = '0;
    done_out = 1'h0;
  end
  // Data is only valid with the pulse, so idle lines carry the inverse
  task scan(input logic [15:0] b, input logic [14:0] c);
    beam_out <= b;
    cross_out <= c;
    done_out <= 1'h1;
    @(posedge clk_in);
    beam_out <= ~b;
    cross_out <= ~c;
    done_out <= 1'h0;
  endtask : scan
endmodule : beo_scan_model

`default_nettype wire

/* tb/beo_top_bench.sv */
// Self-checking bench for the beam evaluation options block.
// Assumes sole bus mastership; scans go through the model.
`timescale 1ns/1ns
`default_nettype none

module beo_top_bench;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] din = 2'h0;
  wire logic hrdy, hresp, sdone, hs, par, csw, cms, det, hold, teach;
  wire logic [31:0] hrdata;
  wire logic [15:0] bb;
  wire logic [14:0] cb;
  wire logic [30:0] bst;
  wire logic [5:0] bcnt;
  int err_total = 0;
  int total_checks = 0;
  int seed = 18694;
  int k;
  logic [31:0] q, r, held;

  always #25 clk = ~clk;

  beo_scan_model u_scn (.clk_in(clk), .beam_out(bb), .cross_out(cb), .done_out(sdone));

  beo_top u_dut (
    .CORE_CLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hrdy),
    .HREADYOUT_OUT(hrdy), .HRDATA_OUT(hrdata), .HRESP_OUT(hresp), .BEAM_BLOCKED_IN(bb),
    .CROSS_BLOCKED_IN(cb), .SCAN_DONE_IN(sdone), .HIGH_SPEED_OUT(hs), .PARALLEL_OUT(par),
    .CROSS_SWITCH_OUT(csw), .CROSS_MEASURE_OUT(cms), .BEAM_STATE_OUT(bst), .BEAM_COUNT_OUT(bcnt),
    .OBJECT_DETECT_OUT(det), .HOLD_ACTIVE_OUT(hold), .DIN_IN(din), .TEACH_START_OUT(teach)
  );

  // ==========================================================================
  // Helpers
  task end_sim;
    if (err_total == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'h1 && n < 40);
    if (hrdy !== 1'h1) begin
      err_total++;
      end_sim;
    end
  endtask : wait_rdy

  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy;
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask : xf

  // Outputs settle one edge after a write
  task wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'h1, a, d);
    repeat (2) @(posedge clk);
  endtask : wr

  task rd(input logic [7:0] a);
    xf(1'h0, a, 32'h0);
  endtask : rd

  task sc(input logic [15:0] b, input logic [14:0] c);
    u_scn.scan(b, c);
    repeat (2) @(posedge clk);
  endtask : sc

  function automatic logic [30:0] ilv(input logic [15:0] b, input logic [14:0] c);
    logic [30:0] v;
    for (int i = 0; i < 16; i++) begin
      v[2*i] = b[i];
      if (i < 15) v[2*i+1] = c[i];
    end
    return v;
  endfunction : ilv

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rd(beo_pkg::OFS_PERF);
    chk(q, 32'h5);
    rd(beo_pkg::OFS_STATUS);
    chk(q, 32'h1011);
    for (k = 0; k < 2; k++) begin
      wr(beo_pkg::OFS_PERF, 32'h4 | k);
      chk(hs, 32'(k == 0));
      chk(par, 32'h1);
    end
    wr(beo_pkg::OFS_PERF, 32'h4);
    wr(beo_pkg::OFS_ENERGY, 32'h1);
    chk(hs, 32'h0);
    wr(beo_pkg::OFS_PERF, 32'h4);
    rd(beo_pkg::OFS_STATUS);
    chk(q[1:0], beo_pkg::RESP_MEDIUM);
    wr(beo_pkg::OFS_ENERGY, 32'h0);
    wr(beo_pkg::OFS_PERF, 32'h5);
    wr(beo_pkg::OFS_MODE, 32'h32);
    for (k = 0; k < 4; k++) begin
      wr(beo_pkg::OFS_PERF, 32'h2 | (k << 4));
      rd(beo_pkg::OFS_PERF);
      chk(q, 32'hD | ((k < 3 ? k : 2) << 4));
    end
    wr(beo_pkg::OFS_MODE, 32'h12);
    chk(csw, 32'h0);
    wr(beo_pkg::OFS_MODE, 32'h10);
    chk(csw, 32'h1);
    rd(beo_pkg::OFS_STATUS);
    chk(q[1:0], beo_pkg::RESP_SLOW);
    r = $random(seed);
    sc(16'h0, r[14:0] | 15'h1);
    chk(bst, 32'h0);
    chk(det, 32'h1);
    wr(beo_pkg::OFS_MODE, 32'h20);
    chk(bcnt, beo_pkg::COUNT_MEASURE);
    r = $random(seed);
    sc(r[15:0], r[30:16]);
    chk(bst, ilv(r[15:0], r[30:16]));
    wr(beo_pkg::OFS_MODE, 32'h0);
    for (k = 0; k < 2; k++) begin
      wr(beo_pkg::OFS_OBJECT, 32'h13 + k);
      chk(csw, 32'(k == 0));
    end
    wr(beo_pkg::OFS_MODE, 32'h34);
    // Pass 0: fieldbus trigger, pass 1: digital input 0
    for (k = 0; k < 2; k++) begin
      wr(beo_pkg::OFS_BEVAL, k ? 32'h11 : 32'h09);
      din <= {1'h0, k[0]};
      repeat (3) @(posedge clk);
      held = 32'h0;
      sc(16'h0, 15'h0);
      repeat (4) begin
        r = $random(seed);
        sc(r[15:0], 15'h0);
        held = held | {16'h0, r[15:0]};
        chk(bst, held);
      end
      chk(hold, 32'h1);
      rd(beo_pkg::OFS_RESULT);
      chk(q[5:0], 6'($countones(held)));
      wr(beo_pkg::OFS_BEVAL, 32'h1);
      din <= 2'h0;
      sc(16'h0, 15'h0);
      sc(16'h0, 15'h0);
      chk(bst, 32'h0);
      chk(hold, 32'h0);
    end
    wr(beo_pkg::OFS_MODE, 32'h38);
    r = $random(seed) | 32'h3;
    sc(r[15:0], 15'h0);
    sc(16'h0, 15'h0);
    chk(bst, r[15:0]);
    sc(r[15:0] ^ 16'h1, 15'h0);
    sc(16'h0, 15'h0);
    chk(bst, r[15:0] ^ 16'h1);
    wr(beo_pkg::OFS_MODE, 32'h3C);
    rd(beo_pkg::OFS_MODE);
    chk(q[5:0], 6'h38);
    rd(8'h20);
    chk(q, 32'h0);
    wr(beo_pkg::OFS_BEVAL, 32'h51);
    rd(beo_pkg::OFS_BEVAL);
    chk(q[7:0], 8'h01);
    wr(beo_pkg::OFS_BEVAL, 32'h80);
    din <= 2'h2;
    q = 32'h0;
    repeat (8) begin
      @(posedge clk);
      q = q + teach;
    end
    chk(q, 32'h1);
    end_sim;
  end
endmodule : beo_top_bench

`default_nettype wire

/* verilog/beo_pkg.sv */
// Constants, register map and codes for the beam evaluation options block.
// Assumes a single 20 MHz core clock and an AHB-Lite master on the register bus.
//
// Functional notes
// RULE_01: Fast response setting means high-speed scan plus parallel beams.
// RULE_02: Medium response setting means no high-speed scan, parallel beams kept.
// RULE_03: Fast response is refused while the energy option disables high-speed scan.
// RULE_04: Transparent mode allows only the medium response setting.
// RULE_05: Any active cross-beam function forces the slow response setting.
// RULE_06: No operating reserve can be chosen in transparent mode.
// RULE_07: Transparent mode needs one of three absorption thresholds: 10, 15, 30 percent.
// RULE_08: Cross beams only in standard or dust mode, high-speed scan off.
// RULE_09: Cross-beam measuring needs at most 255 physical beams.
// RULE_10: Auto choice by object size, or manual cross switching or measuring.
// RULE_11: Cross switching adds crossed beams to detection, beam status unchanged.
// RULE_12: Cross measuring merges each crossed group into one virtual beam.
// RULE_13: Cross measuring renumbers real and virtual beams interleaved, nearly doubling count.
// RULE_14: Configuring party must revise beam-number settings after enabling measuring.
// RULE_15: Response selection never re-enables high-speed scan disabled by energy option.
// RULE_16: Exactly one evaluation mode: standard, held-blocked or last-blocked hold.
// RULE_17: Held-blocked is active while hardware input or fieldbus trigger asserted.
// RULE_18: Held-blocked latches each blocked beam until the trigger goes away.
// RULE_19: Withdrawing the held-blocked trigger clears all latched beams to made.
// RULE_20: Held results only for selected beam functions, others use live status.
// RULE_21: Each digital input has one function; trigger input cannot start teach-in.
// RULE_22: Last-blocked hold keeps the last blocked beam until another is blocked.
// RULE_23: A different blocked beam replaces the stored last-blocked position.
// RULE_24: Last-blocked hold applies to all beam functions at once.
// RULE_25: Hold latches update per finished scan; trigger sampled at scan start.

package beo_pkg;
  // ==========================================================================
  // Geometry
  localparam int NUM_BEAMS = 16;
  localparam int NUM_CROSS = NUM_BEAMS - 1;
  localparam int MAX_BEAMS = NUM_BEAMS + NUM_CROSS;
  localparam int MAX_MEAS_BEAMS = 255;
  localparam logic MEAS_OK = (NUM_BEAMS <= MAX_MEAS_BEAMS);
  localparam logic [5:0] COUNT_PARALLEL = 6'(NUM_BEAMS);
  localparam logic [5:0] COUNT_MEASURE = 6'(MAX_BEAMS);
  // Smallest object size in millimetres below which auto mode uses cross beams
  localparam logic [7:0] AUTO_CROSS_SIZE = 8'h14;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_PERF = 8'h04;
  localparam logic [7:0] OFS_ENERGY = 8'h08;
  localparam logic [7:0] OFS_OBJECT = 8'h0C;
  localparam logic [7:0] OFS_BEVAL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_BEAMS = 8'h18;
  localparam logic [7:0] OFS_RESULT = 8'h1C;

  // ==========================================================================
  // Field positions (LSB of each two-bit field; F_HSDIS and F_TCMD are one bit, F_SEL is three bits)
  localparam int F_OPMODE = 0;
  localparam int F_EVAL = 2;
  localparam int F_CROSS = 4;
  localparam int F_RESP = 0;
  localparam int F_RESV = 2;
  localparam int F_MDA = 4;
  localparam int F_HSDIS = 0;
  localparam int F_SEL = 0;
  localparam int F_TCMD = 3;
  localparam int F_TRIGIN = 4;
  localparam int F_TEACHIN = 6;

  // ==========================================================================
  // Codes
  localparam logic [1:0] OP_STANDARD = 2'h0;
  localparam logic [1:0] OP_DUST = 2'h1;
  localparam logic [1:0] OP_TRANSP = 2'h2;
  localparam logic [1:0] RESP_FAST = 2'h0;
  localparam logic [1:0] RESP_MEDIUM = 2'h1;
  localparam logic [1:0] RESP_SLOW = 2'h2;
  localparam logic [1:0] RESV_NONE = 2'h3;
  localparam logic [1:0] CROSS_AUTO = 2'h0;
  localparam logic [1:0] CROSS_SW = 2'h1;
  localparam logic [1:0] CROSS_MEAS = 2'h2;
  localparam logic [1:0] CROSS_OFF = 2'h3;
  localparam logic [1:0] INVALID_CODE = 2'h3;
  localparam logic [1:0] IN_NONE = 2'h0;

  typedef enum logic [1:0] {
    BEO_EVAL_STANDARD,
    BEO_EVAL_HELD,
    BEO_EVAL_LAST
  } beo_eval_type;

  // ==========================================================================
  // Reset values
  localparam logic [1:0] RST_RESP = RESP_MEDIUM;
  localparam logic [1:0] RST_RESV = 2'h1;
  localparam logic [1:0] RST_MDA = 2'h0;
  localparam logic [1:0] RST_CROSS = CROSS_OFF;
  localparam logic [7:0] RST_OBJECT = 8'h32;
  localparam logic [2:0] RST_SEL = 3'h0;
endpackage : beo_pkg

/* verilog/beo_top.sv */
// Beam evaluation options: option resolution, cross-beam numbering and hold modes.
// Assumes beam inputs and the scan-done pulse come from the scanner on CORE_CLK_IN;
// the digital inputs are asynchronous pins.
`timescale 1ns/1ns
`default_nettype none

module beo_top (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_B_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic HREADYOUT_OUT,
  output logic [31:0] HRDATA_OUT,
  output logic HRESP_OUT,
  // Scanner
  input wire logic [beo_pkg::NUM_BEAMS-1:0] BEAM_BLOCKED_IN,
  input wire logic [beo_pkg::NUM_CROSS-1:0] CROSS_BLOCKED_IN,
  input wire logic SCAN_DONE_IN,
  output logic HIGH_SPEED_OUT,
  output logic PARALLEL_OUT,
  output logic CROSS_SWITCH_OUT,
  output logic CROSS_MEASURE_OUT,
  // Evaluation results
  output logic [beo_pkg::MAX_BEAMS-1:0] BEAM_STATE_OUT,
  output logic [5:0] BEAM_COUNT_OUT,
  output logic OBJECT_DETECT_OUT,
  output logic HOLD_ACTIVE_OUT,
  // Digital inputs
  input wire logic [1:0] DIN_IN,
  output logic TEACH_START_OUT
);

  localparam int MB = beo_pkg::MAX_BEAMS;

  // ==========================================================================
  // Helpers
  function automatic logic [5:0] cnt_blk(input logic [MB-1:0] v);
    logic [5:0] c;
    c = 6'h00;
    for (int i = 0; i < MB; i++) begin
      c = c + 6'(v[i]);
    end
    return c;
  endfunction : cnt_blk

  // Beam numbers start at one; zero means no blocked beam
  function automatic logic [5:0] first_blk(input logic [MB-1:0] v);
    logic [5:0] p;
    p = 6'h00;
    for (int i = MB - 1; i >= 0; i--) begin
      if (v[i]) begin
        p = 6'(i + 1);
      end
    end
    return p;
  endfunction : first_blk

  function automatic logic [5:0] last_blk(input logic [MB-1:0] v);
    logic [5:0] p;
    p = 6'h00;
    for (int i = 0; i < MB; i++) begin
      if (v[i]) begin
        p = 6'(i + 1);
      end
    end
    return p;
  endfunction : last_blk

  function automatic logic [MB-1:0] pick(input logic [1:0] mode, input logic sel,
                                         input logic [MB-1:0] live, input logic [MB-1:0] held,
                                         input logic [MB-1:0] last);
    logic [MB-1:0] r;
    r = live;
    if (mode == 2'(beo_pkg::BEO_EVAL_LAST)) begin
      r = last; // RULE_24
    end else if (mode == 2'(beo_pkg::BEO_EVAL_HELD) && sel) begin
      r = held; // RULE_20
    end
    return r;
  endfunction : pick

  // ==========================================================================
  // Configuration registers
  logic [1:0] op_mode_q;
  logic [1:0] eval_q;
  logic [1:0] cross_q;
  logic [1:0] resp_q;
  logic [1:0] resv_q;
  logic [1:0] mda_q;
  logic hs_dis_q;
  logic [7:0] obj_size_q;
  logic [2:0] sel_q;
  logic tcmd_q;
  logic [1:0] trig_in_q;
  logic [1:0] teach_in_q;

  // ==========================================================================
  // Bus slave
  logic [7:0] addr_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic [31:0] rdata;
  logic [31:0] status_w;
  logic [31:0] result_w;
  logic addr_ok;
  logic [1:0] w_op;
  logic [1:0] w_eval;
  logic [1:0] w_resp;
  logic [1:0] w_resv;
  logic [1:0] w_mda;
  logic [1:0] w_trig;
  logic [1:0] w_teach;
  logic transp;

  assign addr_ok = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  assign w_op = HWDATA_IN[beo_pkg::F_OPMODE +: 2];
  assign w_eval = HWDATA_IN[beo_pkg::F_EVAL +: 2];
  assign w_resp = HWDATA_IN[beo_pkg::F_RESP +: 2];
  assign w_resv = HWDATA_IN[beo_pkg::F_RESV +: 2];
  assign w_mda = HWDATA_IN[beo_pkg::F_MDA +: 2];
  assign w_trig = HWDATA_IN[beo_pkg::F_TRIGIN +: 2];
  assign w_teach = HWDATA_IN[beo_pkg::F_TEACHIN +: 2];
  assign transp = (op_mode_q == beo_pkg::OP_TRANSP);

  // Reads take one wait state so a write just before is always seen
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      addr_q <= 8'h00;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hready_q <= 1'b1;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= 1'b0;
      if (rd_pend_q) begin
        hrdata_q <= rdata;
        hready_q <= 1'b1;
        rd_pend_q <= 1'b0;
      end else if (addr_ok) begin
        addr_q <= HADDR_IN[7:0];
        wr_pend_q <= HWRITE_IN && (HSIZE_IN == 3'h2) && (HADDR_IN[31:8] == 24'h000000);
        rd_pend_q <= !HWRITE_IN;
        hready_q <= HWRITE_IN;
      end
    end
  end

  always_comb begin
    rdata = 32'h00000000;
    case (addr_q)
      beo_pkg::OFS_MODE: rdata = {26'h0000000, cross_q, eval_q, op_mode_q};
      beo_pkg::OFS_PERF: rdata = {26'h0000000, mda_q, transp ? beo_pkg::RESV_NONE : resv_q, resp_q}; // RULE_06
      beo_pkg::OFS_ENERGY: rdata = {31'h00000000, hs_dis_q};
      beo_pkg::OFS_OBJECT: rdata = {24'h000000, obj_size_q};
      beo_pkg::OFS_BEVAL: rdata = {24'h000000, teach_in_q, trig_in_q, tcmd_q, sel_q};
      beo_pkg::OFS_STATUS: rdata = status_w;
      beo_pkg::OFS_BEAMS: rdata = {1'b0, BEAM_STATE_OUT};
      beo_pkg::OFS_RESULT: rdata = result_w;
      default: rdata = 32'h00000000;
    endcase
  end

  // Refused values leave the field unchanged
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      op_mode_q <= beo_pkg::OP_STANDARD;
      eval_q <= 2'(beo_pkg::BEO_EVAL_STANDARD);
      cross_q <= beo_pkg::RST_CROSS;
    end else if (wr_pend_q && addr_q == beo_pkg::OFS_MODE) begin
      if (w_op != beo_pkg::INVALID_CODE) begin
        op_mode_q <= w_op;
      end
      if (w_eval != beo_pkg::INVALID_CODE) begin
        eval_q <= w_eval; // RULE_16
      end
      cross_q <= HWDATA_IN[beo_pkg::F_CROSS +: 2]; // RULE_10
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      resp_q <= beo_pkg::RST_RESP;
      resv_q <= beo_pkg::RST_RESV;
      mda_q <= beo_pkg::RST_MDA;
    end else if (wr_pend_q && addr_q == beo_pkg::OFS_PERF) begin
      if (w_resp != beo_pkg::INVALID_CODE &&
          !(w_resp == beo_pkg::RESP_FAST && hs_dis_q) && // RULE_03
          !(transp && w_resp != beo_pkg::RESP_MEDIUM)) begin // RULE_04
        resp_q <= w_resp;
      end
      if (!transp && w_resv != beo_pkg::INVALID_CODE) begin
        resv_q <= w_resv; // RULE_06
      end
      if (w_mda != beo_pkg::INVALID_CODE) begin
        mda_q <= w_mda; // RULE_07
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      hs_dis_q <= 1'b0;
      obj_size_q <= beo_pkg::RST_OBJECT;
    end else if (wr_pend_q) begin
      if (addr_q == beo_pkg::OFS_ENERGY) begin
        hs_dis_q <= HWDATA_IN[beo_pkg::F_HSDIS];
      end
      if (addr_q == beo_pkg::OFS_OBJECT) begin
        obj_size_q <= HWDATA_IN[7:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      sel_q <= beo_pkg::RST_SEL;
      tcmd_q <= 1'b0;
      trig_in_q <= beo_pkg::IN_NONE;
      teach_in_q <= beo_pkg::IN_NONE;
    end else if (wr_pend_q && addr_q == beo_pkg::OFS_BEVAL) begin
      sel_q <= HWDATA_IN[beo_pkg::F_SEL +: 3];
      tcmd_q <= HWDATA_IN[beo_pkg::F_TCMD];
      // One function per input: a clash keeps both assignments as they were
      if (!(w_trig != beo_pkg::IN_NONE && w_trig == w_teach) &&
          w_trig != beo_pkg::INVALID_CODE && w_teach != beo_pkg::INVALID_CODE) begin
        trig_in_q <= w_trig; // RULE_21
        teach_in_q <= w_teach; // RULE_21
      end
    end
  end

  // ==========================================================================
  // Option resolution
  logic cross_ok;
  logic cross_sw;
  logic cross_meas;
  logic [1:0] resp_eff;

  assign cross_ok = !transp; // RULE_08
  assign cross_meas = cross_ok && beo_pkg::MEAS_OK && (cross_q == beo_pkg::CROSS_MEAS); // RULE_09
  assign cross_sw = cross_ok && ((cross_q == beo_pkg::CROSS_SW) ||
                    (cross_q == beo_pkg::CROSS_AUTO && obj_size_q < beo_pkg::AUTO_CROSS_SIZE)); // RULE_10

  always_comb begin
    resp_eff = resp_q;
    if (cross_sw || cross_meas) begin
      resp_eff = beo_pkg::RESP_SLOW; // RULE_05
    end else if (transp) begin
      resp_eff = beo_pkg::RESP_MEDIUM; // RULE_04
    end else if (hs_dis_q && resp_q == beo_pkg::RESP_FAST) begin
      resp_eff = beo_pkg::RESP_MEDIUM; // RULE_15
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      HIGH_SPEED_OUT <= 1'b0;
      PARALLEL_OUT <= 1'b1;
      CROSS_SWITCH_OUT <= 1'b0;
      CROSS_MEASURE_OUT <= 1'b0;
      BEAM_COUNT_OUT <= beo_pkg::COUNT_PARALLEL;
    end else begin
      HIGH_SPEED_OUT <= (resp_eff == beo_pkg::RESP_FAST) && !hs_dis_q; // RULE_01 RULE_08 RULE_15
      PARALLEL_OUT <= (resp_eff != beo_pkg::RESP_SLOW); // RULE_01 RULE_02
      CROSS_SWITCH_OUT <= cross_sw && !cross_meas;
      CROSS_MEASURE_OUT <= cross_meas;
      BEAM_COUNT_OUT <= cross_meas ? beo_pkg::COUNT_MEASURE : beo_pkg::COUNT_PARALLEL; // RULE_13
    end
  end

  // ==========================================================================
  // Beam numbering and triggers
  logic [MB-1:0] live_w;
  logic [1:0] din_m_q;
  logic [1:0] din_s_q;
  logic trig_now;
  logic teach_lvl;
  logic teach_d_q;

  // In cross measuring, real beams at even positions, virtual beams between them; otherwise real beams in order from position 0
  always_comb begin
    live_w = '0;
    for (int i = 0; i < beo_pkg::NUM_BEAMS; i++) begin
      if (CROSS_MEASURE_OUT) begin
        live_w[2*i] = BEAM_BLOCKED_IN[i]; // RULE_13
      end else begin
        live_w[i] = BEAM_BLOCKED_IN[i];
      end
    end
    for (int i = 0; i < beo_pkg::NUM_CROSS; i++) begin
      if (CROSS_MEASURE_OUT) begin
        live_w[2*i+1] = CROSS_BLOCKED_IN[i]; // RULE_12
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      din_m_q <= 2'h0;
      din_s_q <= 2'h0;
    end else begin
      din_m_q <= DIN_IN;
      din_s_q <= din_m_q;
    end
  end

  assign trig_now = tcmd_q || (trig_in_q == 2'h1 && din_s_q[0]) ||
                    (trig_in_q == 2'h2 && din_s_q[1]); // RULE_17
  assign teach_lvl = (teach_in_q == 2'h1 && din_s_q[0]) || (teach_in_q == 2'h2 && din_s_q[1]);

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      teach_d_q <= 1'b0;
      TEACH_START_OUT <= 1'b0;
    end else begin
      teach_d_q <= teach_lvl;
      TEACH_START_OUT <= teach_lvl && !teach_d_q;
    end
  end

  // ==========================================================================
  // Hold evaluation, updated once per finished scan
  logic [MB-1:0] live_q;
  logic [MB-1:0] held_q;
  logic [MB-1:0] last_q;
  logic trig_s_q;
  logic cross_hit_q;
  logic held_mode;
  logic [MB-1:0] shown;

  assign held_mode = (eval_q == 2'(beo_pkg::BEO_EVAL_HELD));

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      live_q <= '0;
      held_q <= '0;
      last_q <= '0;
      trig_s_q <= 1'b0;
      cross_hit_q <= 1'b0;
    end else if (SCAN_DONE_IN) begin
      live_q <= live_w;
      trig_s_q <= held_mode && trig_now; // RULE_25
      cross_hit_q <= |CROSS_BLOCKED_IN;
      if (held_mode && trig_s_q) begin
        held_q <= held_q | live_w; // RULE_18
      end else begin
        held_q <= '0; // RULE_19
      end
      // Stored beam survives an empty scan, even if the object left the area
      if (|live_w) begin
        last_q <= live_w; // RULE_23
      end // RULE_22
    end
  end

  always_comb begin
    shown = live_q;
    case (eval_q)
      2'(beo_pkg::BEO_EVAL_HELD): shown = held_q;
      2'(beo_pkg::BEO_EVAL_LAST): shown = last_q;
      default: shown = live_q;
    endcase
  end

  // ==========================================================================
  // Beam functions and status
  logic [5:0] nbb_q;
  logic [5:0] fbb_q;
  logic [5:0] lbb_q;

  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      BEAM_STATE_OUT <= '0;
      OBJECT_DETECT_OUT <= 1'b0;
      HOLD_ACTIVE_OUT <= 1'b0;
      nbb_q <= 6'h00;
      fbb_q <= 6'h00;
      lbb_q <= 6'h00;
    end else begin
      BEAM_STATE_OUT <= shown; // RULE_11
      // Crossed beams also count for detection without touching beam status
      OBJECT_DETECT_OUT <= (|shown) || (CROSS_SWITCH_OUT && cross_hit_q); // RULE_11
      HOLD_ACTIVE_OUT <= held_mode && trig_s_q;
      nbb_q <= cnt_blk(pick(eval_q, sel_q[0], live_q, held_q, last_q));
      fbb_q <= first_blk(pick(eval_q, sel_q[1], live_q, held_q, last_q));
      lbb_q <= last_blk(pick(eval_q, sel_q[2], live_q, held_q, last_q));
    end
  end

  assign status_w = {16'h0000, 2'h0, BEAM_COUNT_OUT, HOLD_ACTIVE_OUT, CROSS_MEASURE_OUT,
                     CROSS_SWITCH_OUT, PARALLEL_OUT, HIGH_SPEED_OUT, 1'b0, resp_eff};
  assign result_w = {8'h00, 2'h0, lbb_q, 2'h0, fbb_q, 2'h0, nbb_q};

  // ==========================================================================
  // Bus outputs
  always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      HRESP_OUT <= 1'b0;
    end else begin
      HRESP_OUT <= 1'b0;
    end
  end

  assign HREADYOUT_OUT = hready_q;
  assign HRDATA_OUT = hrdata_q;

endmodule : beo_top

`default_nettype wire
